/* rtl/fbri_top.sv */
// Read side of a burst-capable parallel flash: async reads and wrapping 8-word bursts.
// Assumes the host drives the flash pins; the array is seen through a word port.
// Summary of operation
// - Initial wait states programmable two to seven
// - Extra ready-low cycle at 64-word boundary
// - Edge bit zero falling, one rising
// - Burst ascends within aligned eight words
// - Wraps to lowest word, runs non-stop
// - Burst ends on reset or new address
// - Ready bit one: ready with data
// - Ready bit zero: ready one cycle early
// - Address captured at first edge or strobe rise
// - Async access timed from address capture
// - Reduced handshake: even start shorter than odd
// - Reduced handshake works in synchronous burst
module fbri_top #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic HREADY,
    // Flash pins from the host
    input wire logic FLASH_RESET_N,
    input wire logic CHIP_SELECT_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic BURST_CLK,
    input wire logic ADDRESS_VALID_STROBE_N,
    input wire logic [ADDR_W-1:0] FLASH_ADDR,
    // Flash data and ready pins
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE,
    output logic READY,
    // Array read port
    output logic [ADDR_W-1:0] ARRAY_ADDR,
    input wire logic [DATA_W-1:0] ARRAY_DATA
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each before any logic
    localparam int NSYNC = 5 + ADDR_W;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    always_ff @(posedge CORE_CLK)
    begin
        sync1 <= {FLASH_RESET_N, CHIP_SELECT_N, OUTPUT_ENABLE_N, BURST_CLK, ADDRESS_VALID_STROBE_N, FLASH_ADDR};
        sync2 <= sync1;
        sync3 <= sync2;
    end
    logic frst_n;
    logic ce_n;
    logic oe_n;
    logic bclk;
    logic avd_n;
    logic [ADDR_W-1:0] pin_addr;
    assign {frst_n, ce_n, oe_n, bclk, avd_n, pin_addr} = sync2;
    logic bclk_d;
    logic avd_d;
    assign bclk_d = sync3[ADDR_W+1];
    assign avd_d = sync3[ADDR_W];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register
    logic [7:0] config_reg;
    logic [2:0] wait_states;
    assign wait_states = config_reg[fbri_pkg::CFG_WAIT_LSB +: 3];
    logic edge_select_bit;
    logic ready_timing_bit;
    assign edge_select_bit = config_reg[fbri_pkg::CFG_EDGE_BIT];
    assign ready_timing_bit = config_reg[fbri_pkg::CFG_RDYT_BIT];

    // Active burst-clock edge: zero selects falling, one rising
    logic active_edge;
    assign active_edge = edge_select_bit ? (bclk && !bclk_d) : (!bclk && bclk_d);
    logic avd_rise;
    logic avd_fall;
    assign avd_rise = avd_n && !avd_d;
    assign avd_fall = !avd_n && avd_d;
    logic sel;
    assign sel = !ce_n && frst_n;

    ////////////////////////////////////////////////////////////////////////////
    // Burst engine
    fbri_pkg::fbri_state_t state;
    logic [ADDR_W-1:0] cur_addr;
    logic [3:0] cnt;
    logic boundary_done;
    logic capture;
    logic strobe_armed;
    logic fifo_in_ready;
    // Address taken at the first of active edge or strobe rise
    assign capture = sel && ((strobe_armed && active_edge) || avd_rise);
    logic rws_odd;
    logic [3:0] init_wait;
    always_comb
    begin
        init_wait = {1'b0, wait_states};
        if (config_reg[fbri_pkg::CFG_RWS_BIT])
        begin
            // Even start needs one cycle less in reduced handshake
            init_wait = rws_odd ? {1'b0, wait_states} : {1'b0, wait_states} - 4'h1;
        end
    end
    logic word_due;
    assign word_due = (state == fbri_pkg::ST_BURST) && active_edge && fifo_in_ready;
    logic at_page;
    assign at_page = (cur_addr[fbri_pkg::PAGE_BITS-1:0] == '0) && !boundary_done;

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET || !frst_n)
        begin
            state <= fbri_pkg::ST_IDLE;
            cur_addr <= '0;
            cnt <= fbri_pkg::CNT_ZERO;
            boundary_done <= 1'b0;
            strobe_armed <= 1'b0;
            rws_odd <= 1'b0;
        end
        else
        begin
            if (avd_fall)
            begin
                strobe_armed <= 1'b1;
            end
            if (capture)
            begin
                // New address stops any running burst
                strobe_armed <= 1'b0;
                cur_addr <= pin_addr;
                rws_odd <= pin_addr[0];
                boundary_done <= 1'b0;
                cnt <= fbri_pkg::CNT_ZERO;
                state <= config_reg[fbri_pkg::CFG_SYNC_BIT] ? fbri_pkg::ST_WAIT : fbri_pkg::ST_ASYNC;
            end
            else
            begin
                case (state)
                    fbri_pkg::ST_WAIT:
                    begin
                        if (active_edge)
                        begin
                            cnt <= cnt + 4'h1;
                            if (cnt + 4'h1 >= init_wait)
                            begin
                                state <= fbri_pkg::ST_BURST;
                            end
                        end
                    end
                    fbri_pkg::ST_BURST:
                    begin
                        if (word_due && at_page)
                        begin
                            boundary_done <= 1'b1;
                        end
                        else if (word_due)
                        begin
                            // Ascend inside the aligned group, wrap to its lowest word
                            cur_addr[fbri_pkg::WRAP_BITS-1:0] <= cur_addr[fbri_pkg::WRAP_BITS-1:0] + 3'h1;
                            boundary_done <= 1'b0;
                        end
                    end
                    fbri_pkg::ST_ASYNC:
                    begin
                        if (cnt < 4'(fbri_pkg::ASYNC_ACC_CYC))
                        begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    fbri_pkg::ST_IDLE:
                    begin
                        cnt <= fbri_pkg::CNT_ZERO;
                    end
                    default:
                    begin
                        state <= fbri_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word FIFO between array and data pins; it takes a word only on an active clock edge
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic fifo_pop;
    logic push_word;
    assign push_word = word_due && !at_page;
    fbri_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst(RESET || capture || !frst_n),
        .in_valid(push_word),
        .in_ready(fifo_in_ready),
        .in_data(ARRAY_DATA),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );
    assign fifo_pop = fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Data and ready pins
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            DATA_OUT <= '0;
            DATA_OE <= 1'b0;
            READY <= 1'b0;
            ARRAY_ADDR <= '0;
        end
        else
        begin
            ARRAY_ADDR <= cur_addr;
            DATA_OE <= sel && !oe_n;
            if (state == fbri_pkg::ST_ASYNC && cnt >= 4'(fbri_pkg::ASYNC_ACC_CYC))
            begin
                DATA_OUT <= ARRAY_DATA;
            end
            else if (fifo_pop)
            begin
                DATA_OUT <= fifo_out_data;
            end
            // Ready with data or one cycle ahead of it
            if (ready_timing_bit)
            begin
                READY <= fifo_pop;
            end
            else
            begin
                READY <= push_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic take;
    assign take = HSEL && HREADY && (HTRANS == fbri_pkg::HTRANS_NONSEQ);
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
            config_reg <= {5'h00, fbri_pkg::WAIT_RESET};
            HRDATA <= '0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            wr_pend <= take && HWRITE;
            rd_pend <= take && !HWRITE;
            wr_addr <= HADDR[7:0];
            rd_addr <= HADDR[7:0];
            if (wr_pend && wr_addr == fbri_pkg::REG_CONFIG)
            begin
                // Out-of-range wait counts are clamped to the legal window
                config_reg <= HWDATA[7:0];
                if (HWDATA[2:0] < fbri_pkg::WAIT_MIN)
                begin
                    config_reg[2:0] <= fbri_pkg::WAIT_MIN;
                end
            end
            if (take && !HWRITE)
            begin
                case (HADDR[7:0])
                    fbri_pkg::REG_CONFIG: HRDATA <= {24'h000000, config_reg};
                    fbri_pkg::REG_STATUS: HRDATA <= {24'h000000, READY, DATA_OE, boundary_done, state, rws_odd};
                    fbri_pkg::REG_ADDR: HRDATA <= 32'(cur_addr);
                    default: HRDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : fbri_top

/* rtl/fbri_pkg.sv */
// Constants for the burst flash read interface.
// Assumes a single 50 MHz core clock; times are turned into cycle counts here.
package fbri_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Wait states, linear wrap and page boundary
    localparam logic [2:0] WAIT_MIN = 3'h2;
    localparam logic [2:0] WAIT_MAX = 3'h7;
    localparam logic [2:0] WAIT_RESET = 3'h7;
    localparam int WRAP_BITS = 3;
    localparam int PAGE_BITS = 6;
    // Asynchronous access time and reduced-handshake latencies
    localparam int ASYNC_ACC_NS = 70;
    localparam int ASYNC_ACC_CYC = ASYNC_ACC_NS / CLK_PERIOD_NS;
    localparam int RWS_EVEN_NS = 88;
    localparam int RWS_ODD_NS = 106;
    localparam int RWS_EVEN_CYC = RWS_EVEN_NS / CLK_PERIOD_NS;
    localparam int RWS_ODD_CYC = RWS_ODD_NS / CLK_PERIOD_NS;
    // Power-up reset hold the host must respect
    localparam int RESET_HOLD_US = 50;
    localparam int RESET_HOLD_CYC = RESET_HOLD_US * 1000 / CLK_PERIOD_NS;
    // AHB-Lite register map
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam int CFG_WAIT_LSB = 0;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_RDYT_BIT = 5;
    localparam int CFG_SYNC_BIT = 6;
    localparam int CFG_RWS_BIT = 7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_BURST = 4'b0100,
        ST_ASYNC = 4'b1000
    } fbri_state_t;
endpackage : fbri_pkg

/* rtl/fbri_fifo.sv */
// Small valid/ready FIFO in flip-flops.
// Assumes both sides run on the same clock.
module fbri_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Accepts whenever a slot is free, the empty state included
    assign in_ready = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : fbri_fifo

/* bench/fbri_monitor.sv */
// Checker for the burst flash read interface.
// Assumes it is bound onto fbri_top and sees only its ports.
module fbri_monitor #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    // Flash pins
    input wire logic FLASH_RESET_N,
    input wire logic CHIP_SELECT_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic ADDRESS_VALID_STROBE_N,
    input wire logic [ADDR_W-1:0] FLASH_ADDR,
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic DATA_OE,
    input wire logic READY,
    input wire logic [ADDR_W-1:0] ARRAY_ADDR
);
    logic wr_cfg;
    logic rt;
    logic strobe_q;
    logic [ADDR_W-1:0] cap;
    logic [3:0] quiet;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    ////////////////////////////////////////
    // Ready timing is shadowed from config writes
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            wr_cfg <= 1'b0;
            rt <= 1'b0;
        end
        else
        begin
            wr_cfg <= HSEL && HREADY && HWRITE && HTRANS == fbri_pkg::HTRANS_NONSEQ
                && HADDR[7:0] == fbri_pkg::REG_CONFIG;
            if (wr_cfg)
                rt <= HWDATA[fbri_pkg::CFG_RDYT_BIT];
        end
    end
    always_ff @(posedge CORE_CLK)
    begin
        strobe_q <= ADDRESS_VALID_STROBE_N;
        if (ADDRESS_VALID_STROBE_N && !strobe_q)
            cap <= FLASH_ADDR;
    end
    // Long after a capture, any address change must be a burst step
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET || !ADDRESS_VALID_STROBE_N || !FLASH_RESET_N)
            quiet <= 4'h0;
        else if (quiet != 4'hF)
            quiet <= quiet + 4'h1;
    end
    ////////////////////////////////////////
    a_addr_capture: assert property (
        $rose(ADDRESS_VALID_STROBE_N) && !CHIP_SELECT_N |-> ##[1:6] ARRAY_ADDR == cap)
        else $error("address not captured");
    a_wrap_step: assert property (
        quiet == 4'hF && $changed(ARRAY_ADDR) |-> ARRAY_ADDR[ADDR_W-1:3] == $past(ARRAY_ADDR[ADDR_W-1:3])
        && ARRAY_ADDR[2:0] == $past(ARRAY_ADDR[2:0]) + 3'h1)
        else $error("burst step wrong");
    a_ready_single: assert property (READY |=> !READY)
        else $error("ready longer than one cycle");
    a_rdy_with_data: assert property (rt && READY |-> $changed(DATA_OUT))
        else $error("ready without new data");
    a_rdy_early: assert property (
        !rt && READY |-> $stable(DATA_OUT) ##1 $changed(DATA_OUT))
        else $error("ready not one cycle early");
    a_oe_on: assert property (
        (!CHIP_SELECT_N && !OUTPUT_ENABLE_N && FLASH_RESET_N) [*4] |-> DATA_OE)
        else $error("data not driven");
    a_oe_off: assert property (CHIP_SELECT_N [*4] |-> !DATA_OE)
        else $error("data driven while deselected");
    a_reset_stops: assert property (!FLASH_RESET_N [*6] |-> !READY && !DATA_OE)
        else $error("activity during flash reset");
endmodule : fbri_monitor

bind fbri_top fbri_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_fbri_monitor (.*);

/* bench/fbri_host.sv */
// Host memory controller model driving the flash pins.
// Assumes one core clock; the burst clock moves only in the clock and idle_level tasks.
module fbri_host #(
    parameter int ADDR_W = 21,
    parameter int HOLD_CYC = fbri_pkg::RESET_HOLD_CYC
) (
    // Core clock
    input wire logic clk,
    // Flash pins
    output logic flash_reset_n,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic burst_clk,
    output logic address_valid_strobe_n,
    output logic [ADDR_W-1:0] flash_addr
);
    int edges = 0;
    logic rising = 1'b1;
    ////////////////////////////////////////
    // Power-up hold kept at the full reset time
    initial
    begin
        flash_reset_n = 1'b0;
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
        burst_clk = 1'b0;
        address_valid_strobe_n = 1'b1;
        flash_addr = '0;
        repeat (HOLD_CYC) @(posedge clk);
        flash_reset_n <= 1'b1;
    end
    // Parked on the inactive level, so an edge-select change makes no active edge
    task automatic idle_level(input logic r);
        rising = r;
        burst_clk <= ~r;
    endtask : idle_level
    task automatic start(input logic [ADDR_W-1:0] a, input logic sync);
        @(posedge clk);
        chip_select_n <= 1'b0;
        output_enable_n <= 1'b0;
        flash_addr <= a;
        address_valid_strobe_n <= 1'b0;
        repeat (3) @(posedge clk);
        address_valid_strobe_n <= 1'b1;
        edges = 0;
        repeat (3) @(posedge clk);
        if (sync)
            flash_addr <= ~a;
    endtask : start
    task automatic clock(input int n);
        repeat (n)
        begin
            repeat (5) @(posedge clk);
            burst_clk <= rising;
            edges = edges + 1;
            repeat (5) @(posedge clk);
            burst_clk <= ~rising;
        end
    endtask : clock
    task automatic pulse_reset();
        flash_reset_n <= 1'b0;
        // Long enough for the checker to see a settled reset
        repeat (8) @(posedge clk);
        flash_reset_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : pulse_reset
endmodule : fbri_host

/* bench/testbench.sv */
// Testbench for the burst flash read interface, FIFO seen through the top.
// Assumes the host model drives the pins and a pattern array answers reads.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 1'b0;
    logic RESET, HSEL, HWRITE, HREADYOUT, HRESP, HREADY;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic FLASH_RESET_N, CHIP_SELECT_N, OUTPUT_ENABLE_N, BURST_CLK, ADDRESS_VALID_STROBE_N, DATA_OE, READY;
    logic [20:0] FLASH_ADDR, ARRAY_ADDR;
    logic [15:0] DATA_OUT, ARRAY_DATA;
    logic rt_bit = 1'b0, ready_d = 1'b0;
    logic [31:0] rd;
    logic [2:0] n;
    logic [15:0] q_word[$];
    int q_edge[$];
    int failures = 0;
    int samples_checked = 0;
    assign HREADY = HREADYOUT;
    assign ARRAY_DATA = {ARRAY_ADDR[7:0], ~ARRAY_ADDR[7:0]};
    always #10 CORE_CLK = ~CORE_CLK;
    fbri_top u_fbri_top (.*);
    fbri_host u_fbri_host (.clk(CORE_CLK), .flash_reset_n(FLASH_RESET_N), .chip_select_n(CHIP_SELECT_N),
        .output_enable_n(OUTPUT_ENABLE_N), .burst_clk(BURST_CLK),
        .address_valid_strobe_n(ADDRESS_VALID_STROBE_N), .flash_addr(FLASH_ADDR));
    ////////////////////////////////////////
    // Words are taken where the ready timing says they are valid
    always @(posedge CORE_CLK)
    begin
        if (rt_bit ? READY : ready_d)
        begin
            q_word.push_back(DATA_OUT);
            q_edge.push_back(u_fbri_host.edges);
        end
        ready_d <= READY;
    end
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : check
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= fbri_pkg::HTRANS_NONSEQ;
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
        rd = HRDATA;
    endtask : ahb
    task automatic burst(input logic [7:0] cfg, input logic [20:0] a, input int first, input int nw);
        logic [20:0] ad;
        int e;
        ahb(1'b1, fbri_pkg::REG_CONFIG, {24'h0, cfg});
        rt_bit = cfg[fbri_pkg::CFG_RDYT_BIT];
        u_fbri_host.idle_level(cfg[fbri_pkg::CFG_EDGE_BIT]);
        u_fbri_host.start(a, 1'b1);
        q_word.delete();
        q_edge.delete();
        u_fbri_host.clock(first + nw);
        repeat (12) @(posedge CORE_CLK);
        e = first;
        for (int k = 0; k < nw; k++)
        begin
            ad = {a[20:3], a[2:0] + 3'(k)};
            if (k > 0)
                e = e + ((ad[5:0] == 6'h00) ? 2 : 1);
            check(q_word[k] === {ad[7:0], ~ad[7:0]}, "burst word");
            check(q_edge[k] == e, "word edge");
        end
        $display("burst at %h done", a);
    endtask : burst
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge CORE_CLK);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
    initial
    begin
        RESET = 1'b1;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        HSIZE = 3'h2;
        repeat (5) @(posedge CORE_CLK);
        RESET <= 1'b0;
        wait (FLASH_RESET_N === 1'b1);
        @(posedge CORE_CLK);
        ahb(1'b0, fbri_pkg::REG_CONFIG, 32'h0);
        check(rd[7:0] === 8'h07, "config reset");
        check(HRESP === 1'b0, "bus response");
        ahb(1'b1, fbri_pkg::REG_CONFIG, 32'h01);
        ahb(1'b0, fbri_pkg::REG_CONFIG, 32'h0);
        check(rd[2:0] === fbri_pkg::WAIT_MIN, "wait floor");
        ahb(1'b0, 8'h10, 32'h0);
        check(rd === 32'h0, "unmapped read");
        $display("register test done");
        for (int i = 0; i < 4; i++)
        begin
            n = i[0] ? 3'h7 : 3'h2;
            burst({2'b01, i[0] ^ i[1], i[1], 1'b0, n}, 21'h46, int'(n) + 1, 8);
        end
        burst(8'hF4, 21'h52, 4, 3);
        burst(8'hF4, 21'h53, 5, 3);
        burst(8'h73, 21'h80, 5, 3);
        u_fbri_host.pulse_reset();
        q_word.delete();
        u_fbri_host.clock(12);
        check(q_word.size() == 0, "words after reset");
        ahb(1'b1, fbri_pkg::REG_CONFIG, 32'h07);
        u_fbri_host.start(21'h00123, 1'b0);
        repeat (6) @(posedge CORE_CLK);
        check(DATA_OUT === 16'h23DC && DATA_OE === 1'b1, "async word");
        $display("reset and async test done");
        ahb(1'b0, fbri_pkg::REG_ADDR, 32'h0);
        check(rd === 32'h00000123, "captured address");
        ahb(1'b0, fbri_pkg::REG_STATUS, 32'h0);
        check(rd === {24'h0, 1'b0, 1'b1, 1'b0, fbri_pkg::ST_ASYNC, 1'b1}, "status word");
        $display("readback test done");
        summarize();
    end
endmodule : testbench
